//--- sft_map.vh
`ifndef SFT_MAP_VH
`define SFT_MAP_VH

// system clock rate and derived timing
`define SFT_SYS_CLK_MHZ 40
`define SFT_MIN_PULSE_NS 200
`define SFT_MIN_PULSE_CYC ((`SFT_MIN_PULSE_NS * `SFT_SYS_CLK_MHZ + 999) / 1000)
`define SFT_TXC_STABLE_CYC 1

// line characters
`define SFT_FLAG_CHAR 16'h007e
`define SFT_ABORT_CHAR 16'h00ff
`define SFT_MARK_CHAR 16'hffff
`define SFT_FLAG_BITS 5'h08
`define SFT_ABORT_BITS 5'h08
`define SFT_CRC_BITS 5'h10
`define SFT_STUFF_RUN 3'h5

// crc generator, x^16 + x^12 + x^5 + 1 in bit-reversed form
`define SFT_CRC_PRESET 16'hffff
`define SFT_CRC_POLY_REV 16'h8408

// reset values
`define SFT_RST_UNDERRUN 1'b1
`define SFT_RST_LINE 1'b1

`endif

//--- sft_pin_filter.v
`timescale 1ns/100ps
// two-flop synchroniser followed by a stability filter
module sft_pin_filter #(
    parameter STABLE_CYC = 8,
    parameter INIT = 1'b1
) (
    input wire i_sys_clk,
    input wire i_rstn,
    input wire i_pin,
    output reg o_level,
    output reg o_change
);

reg meta_r;
reg sync_r;
reg [7:0] stable_r;
wire [7:0] stable_lim;

assign stable_lim = STABLE_CYC[7:0];

always @(posedge i_sys_clk or negedge i_rstn)
begin
    if (!i_rstn)
    begin
        meta_r <= INIT;
        sync_r <= INIT;
        stable_r <= 8'h00;
        o_level <= INIT;
        o_change <= 1'b0;
    end
    else
    begin
        meta_r <= i_pin;
        sync_r <= meta_r;
        o_change <= 1'b0;
        if (sync_r == o_level)
        begin
            stable_r <= 8'h00;
        end
        else if (stable_r + 8'h01 >= stable_lim)
        begin
            // level held long enough: accept it
            o_level <= sync_r;
            o_change <= 1'b1;
            stable_r <= 8'h00;
        end
        else
        begin
            stable_r <= stable_r + 8'h01;
        end
    end
end

endmodule // sft_pin_filter

//--- sft_frame_tx.v
// Functional notes
// (R1) software programs mode control first: x1 clock, sdlc, sync modes
// (R2) software loads flag pattern 01111110 in second sync word register
// (R3) rts and dtr pins drive the inverted control bits
// (R4) with auto enable, dcd gates receiver and cts gates transmitter
// (R5) dcd or cts change longer than minimum pulse raises ext/status interrupt
// (R6) no parity is ever added to flags or crc
// (R7) software selects the sdlc crc polynomial; crc-16 is undefined
// (R8) line idles high after reset or disabled; send break forces low
// (R9) enabled with empty buffer sends back-to-back flags
// (R10) character buffered before enable replaces the first flag
// (R11) abort drops data, sends eight ones, then continuous flags
// (R12) insert zero after five ones in frame data, not flags or aborts
// (R13) reset crc command presets generator to all ones
// (R14) frame starts on first buffer write; device adds only flags and crc
// (R15) lsb first, line changes on falling edge of tx bit clock
// (R16) one to eight right-justified bits per character, upper bits ignored
// (R17) character length change applies to buffered characters, not current
// (R18) flags always eight bits, crc always sixteen bits
// (R19) tx interrupt when buffer empties; cleared by write or reset command
// (R20) buffer-empty sets when buffer moves to shifter, clears on write
// (R21) dma request asserted while transmitter needs a character
// (R22) underrun sends crc then flags if underrun bit zero, else flags
// (R23) underrun bit is one after reset, cleared only by its command
// (R24) crc is inverted before transmission
// (R25) first crc bit sets underrun bit and raises ext/status interrupt
// (R26) crc polynomial x^16+x^12+x^5+1 over every frame character
`timescale 1ns/100ps
`include "sft_map.vh"
module sft_frame_tx (
    input wire i_sys_clk,
    input wire i_rstn,
    input wire i_tx_bit_clock,
    input wire i_cts_n,
    input wire i_dcd_n,
    input wire i_tx_enable,
    input wire i_send_break,
    input wire i_rts_bit,
    input wire i_dtr_bit,
    input wire i_auto_enable,
    input wire i_ext_int_enable,
    input wire i_crc_enable,
    input wire [2:0] i_bits_per_char,
    input wire i_cmd_send_abort,
    input wire i_cmd_reset_crc,
    input wire i_cmd_reset_tx_int,
    input wire i_cmd_reset_underrun,
    input wire i_cmd_reset_ext_status,
    input wire i_buf_wr,
    input wire [7:0] i_buf_data,
    output reg o_txd,
    output reg o_rts_n,
    output reg o_dtr_n,
    output reg o_rx_gate,
    output reg o_tx_int,
    output reg o_ext_status_int,
    output reg o_buf_empty,
    output reg o_tx_underrun_end_of_message,
    output reg o_tx_dma_request
);

localparam K_MARK = 3'h0;
localparam K_FLAG = 3'h1;
localparam K_DATA = 3'h2;
localparam K_CRC = 3'h3;
localparam K_ABORT = 3'h4;

// one serial step of the bit-reversed crc
function [15:0] crc_step;
    input [15:0] c;
    input b;
    begin
        if (c[0] ^ b)
            crc_step = (c >> 1) ^ `SFT_CRC_POLY_REV;
        else
            crc_step = c >> 1;
    end
endfunction

// bits per character, code zero meaning eight
function [4:0] char_bits;
    input [2:0] code;
    begin
        if (code == 3'h0)
            char_bits = 5'h08;
        else
            char_bits = {2'b00, code};
    end
endfunction

wire txc_lvl;
wire cts_n_lvl;
wire cts_chg;
wire dcd_n_lvl;
wire dcd_chg;
reg txc_prev_r;
wire tick;
wire tx_go;
wire abort_go;

reg [15:0] sh_r;
reg [4:0] cnt_r;
reg [2:0] kind_r;
reg [2:0] ones_r;
reg [15:0] crc_r;
reg [7:0] buf_r;
reg buf_full_r;
reg abort_pend_r;
reg in_frame_r;
reg crc_sent_r;
reg line_r;

reg [15:0] ld_sh;
reg [4:0] ld_cnt;
reg [2:0] ld_kind;
reg stuff;
reg take_buf;
reg start_crc;
reg load_flag;
reg [15:0] sh_nxt;
reg [4:0] cnt_nxt;
reg [2:0] kind_nxt;
reg [2:0] ones_nxt;
reg [15:0] crc_nxt;
reg line_nxt;
reg buf_full_nxt;

sft_pin_filter #(
    .STABLE_CYC(`SFT_TXC_STABLE_CYC),
    .INIT(1'b1)
) u_txc (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_pin(i_tx_bit_clock),
    .o_level(txc_lvl),
    .o_change()
);

sft_pin_filter #(
    .STABLE_CYC(`SFT_MIN_PULSE_CYC),
    .INIT(1'b1)
) u_cts (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_pin(i_cts_n),
    .o_level(cts_n_lvl),
    .o_change(cts_chg)
);

sft_pin_filter #(
    .STABLE_CYC(`SFT_MIN_PULSE_CYC),
    .INIT(1'b1)
) u_dcd (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_pin(i_dcd_n),
    .o_level(dcd_n_lvl),
    .o_change(dcd_chg)
);

assign tick = txc_prev_r & ~txc_lvl; // R15
assign tx_go = i_tx_enable & (~i_auto_enable | ~cts_n_lvl); // R4
assign abort_go = abort_pend_r & ~((cnt_r != 5'h00) & (kind_r == K_FLAG)); // R11

// choice of the next character at a boundary, or of an abort cutting into a data or crc character
always @*
begin
    ld_sh = sh_r;
    ld_cnt = cnt_r;
    ld_kind = kind_r;
    take_buf = 1'b0;
    start_crc = 1'b0;
    load_flag = 1'b0;
    if (abort_go)
    begin
        ld_sh = `SFT_ABORT_CHAR; // R11
        ld_cnt = `SFT_ABORT_BITS;
        ld_kind = K_ABORT;
    end
    else if (cnt_r == 5'h00)
    begin
        if (!tx_go)
        begin
            ld_sh = `SFT_MARK_CHAR; // R8
            ld_cnt = 5'h00;
            ld_kind = K_MARK;
        end
        else if (buf_full_r)
        begin
            ld_sh = {8'h00, buf_r}; // R10 R14 R16
            ld_cnt = char_bits(i_bits_per_char); // R17
            ld_kind = K_DATA;
            take_buf = 1'b1;
        end
        else if (in_frame_r && !o_tx_underrun_end_of_message)
        begin
            ld_sh = ~crc_r; // R22 R24
            ld_cnt = `SFT_CRC_BITS; // R18
            ld_kind = K_CRC;
            start_crc = 1'b1;
        end
        else
        begin
            ld_sh = `SFT_FLAG_CHAR; // R9 R18 R22
            ld_cnt = `SFT_FLAG_BITS;
            ld_kind = K_FLAG;
            load_flag = 1'b1;
        end
    end
    stuff = ~abort_go & (ones_r == `SFT_STUFF_RUN); // R12
end

// bit emission on each falling tx bit clock edge
always @*
begin
    sh_nxt = sh_r;
    cnt_nxt = cnt_r;
    kind_nxt = kind_r;
    ones_nxt = ones_r;
    crc_nxt = crc_r;
    line_nxt = line_r;
    if (tick)
    begin
        if (stuff)
        begin
            line_nxt = 1'b0; // R12
            ones_nxt = 3'h0;
        end
        else
        begin
            line_nxt = ld_sh[0]; // R6 R15
            sh_nxt = ld_sh >> 1;
            kind_nxt = ld_kind;
            if (ld_cnt == 5'h00)
                cnt_nxt = 5'h00;
            else
                cnt_nxt = ld_cnt - 5'h01;
            if ((ld_kind == K_DATA) || (ld_kind == K_CRC))
                ones_nxt = ld_sh[0] ? ones_r + 3'h1 : 3'h0; // R12
            else
                ones_nxt = 3'h0;
            if ((ld_kind == K_DATA) && i_crc_enable)
                crc_nxt = crc_step(crc_r, ld_sh[0]); // R26
        end
    end
    if (i_cmd_reset_crc)
        crc_nxt = `SFT_CRC_PRESET; // R13
end

always @*
begin
    buf_full_nxt = buf_full_r;
    if (tick && !stuff && take_buf)
        buf_full_nxt = 1'b0;
    if (i_cmd_send_abort)
        buf_full_nxt = 1'b0; // R11
    if (i_buf_wr)
        buf_full_nxt = 1'b1;
end

always @(posedge i_sys_clk or negedge i_rstn)
begin
    if (!i_rstn)
    begin
        txc_prev_r <= 1'b1;
        sh_r <= `SFT_MARK_CHAR;
        cnt_r <= 5'h00;
        kind_r <= K_MARK;
        ones_r <= 3'h0;
        crc_r <= `SFT_CRC_PRESET;
        buf_r <= 8'h00;
        buf_full_r <= 1'b0;
        abort_pend_r <= 1'b0;
        in_frame_r <= 1'b0;
        crc_sent_r <= 1'b0;
        line_r <= `SFT_RST_LINE;
        o_txd <= `SFT_RST_LINE;
        o_rts_n <= 1'b1;
        o_dtr_n <= 1'b1;
        o_rx_gate <= 1'b0;
        o_tx_int <= 1'b0;
        o_ext_status_int <= 1'b0;
        o_buf_empty <= 1'b1;
        o_tx_underrun_end_of_message <= `SFT_RST_UNDERRUN; // R23
        o_tx_dma_request <= 1'b0;
    end
    else
    begin
        txc_prev_r <= txc_lvl;
        sh_r <= sh_nxt;
        cnt_r <= cnt_nxt;
        kind_r <= kind_nxt;
        ones_r <= ones_nxt;
        crc_r <= crc_nxt;
        line_r <= line_nxt;
        buf_full_r <= buf_full_nxt;
        if (i_buf_wr)
            buf_r <= i_buf_data;
        o_txd <= i_send_break ? 1'b0 : line_nxt; // R8
        o_rts_n <= ~i_rts_bit; // R3
        o_dtr_n <= ~i_dtr_bit; // R3
        o_rx_gate <= ~i_auto_enable | ~dcd_n_lvl; // R4
        if (i_cmd_send_abort && (kind_r != K_ABORT))
            abort_pend_r <= 1'b1; // R11
        else if (tick && abort_go)
            abort_pend_r <= 1'b0;
        if (tick && !stuff)
        begin
            if (abort_go || load_flag || start_crc)
                in_frame_r <= 1'b0;
            else if (take_buf)
                in_frame_r <= 1'b1;
            if (start_crc)
                crc_sent_r <= 1'b1;
            else if (load_flag || abort_go)
                crc_sent_r <= 1'b0;
        end
        // tx interrupt: set wins over clear
        if (tick && !stuff && ((take_buf && !i_buf_wr) || (load_flag && crc_sent_r)))
            o_tx_int <= 1'b1; // R19
        else if (i_buf_wr || i_cmd_reset_tx_int || !i_tx_enable)
            o_tx_int <= 1'b0; // R19
        // underrun latch: first crc bit sets, command clears
        if (tick && !stuff && start_crc)
            o_tx_underrun_end_of_message <= 1'b1; // R25
        else if (i_cmd_reset_underrun)
            o_tx_underrun_end_of_message <= 1'b0; // R23
        if ((tick && !stuff && start_crc) || (i_ext_int_enable && (cts_chg || dcd_chg)))
            o_ext_status_int <= 1'b1; // R5 R25
        else if (i_cmd_reset_ext_status)
            o_ext_status_int <= 1'b0;
        o_buf_empty <= ~buf_full_nxt & (kind_nxt != K_CRC); // R20
        o_tx_dma_request <= ~buf_full_nxt & tx_go & (in_frame_r | take_buf) & ~abort_pend_r; // R21
    end
end

endmodule // sft_frame_tx

//--- sft_frame_tx_checker.sv
`timescale 1ns/100ps
module sft_frame_tx_checker (
    input wire i_sys_clk,
    input wire i_rstn,
    input wire i_tx_enable,
    input wire i_send_break,
    input wire i_rts_bit,
    input wire i_ext_int_enable,
    input wire i_cmd_send_abort,
    input wire i_cmd_reset_tx_int,
    input wire i_cmd_reset_underrun,
    input wire i_cmd_reset_ext_status,
    input wire i_buf_wr,
    input wire o_txd,
    input wire o_rts_n,
    input wire o_tx_int,
    input wire o_ext_status_int,
    input wire o_buf_empty,
    input wire o_tx_underrun_end_of_message,
    input wire o_tx_dma_request
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);
    reg [9:0] idle_r;
    // cycles spent disabled without break
    always @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn || i_tx_enable || i_send_break)
            idle_r <= 10'h000;
        else if (idle_r != 10'h3ff)
            idle_r <= idle_r + 10'h001;
    end
    a_rts_inverted: assert property ($past(i_rstn, 2) |-> o_rts_n == !$past(i_rts_bit))
        else $error("rts pin wrong");
    a_break_space: assert property (i_send_break |=> !o_txd)
        else $error("break not spacing");
    a_idle_mark: assert property (idle_r > 10'h1f4 |-> o_txd)
        else $error("idle line not marking");
    a_write_fills: assert property (i_buf_wr && !i_cmd_send_abort |=> !o_buf_empty && !o_tx_dma_request)
        else $error("write left buffer empty");
    a_underrun_hold: assert property ($fell(o_tx_underrun_end_of_message) |-> $past(i_cmd_reset_underrun))
        else $error("underrun bit cleared alone");
    a_ext_hold: assert property ($fell(o_ext_status_int) |-> $past(i_cmd_reset_ext_status))
        else $error("ext interrupt cleared alone");
    a_tx_int_clear: assert property ($fell(o_tx_int) |-> $past(i_buf_wr || i_cmd_reset_tx_int || !i_tx_enable))
        else $error("tx interrupt cleared alone");
    a_eom_ext_int: assert property ($rose(o_tx_underrun_end_of_message) && i_ext_int_enable |-> o_ext_status_int)
        else $error("end of message without interrupt");
    c_eom: cover property ($rose(o_tx_underrun_end_of_message));
    c_abort: cover property (i_cmd_send_abort);
    c_break: cover property (i_send_break ##1 !o_txd);
endmodule // sft_frame_tx_checker
bind sft_frame_tx sft_frame_tx_checker i_chk (.*);

//--- sft_line_model.sv
`timescale 1ns/100ps
module sft_line_model (
    input wire i_run,
    input wire i_txd,
    input wire i_clr,
    output reg o_clk,
    output reg [15:0] o_res,
    output reg [7:0] o_cnt,
    output reg [31:0] o_data,
    output reg [4:0] o_peak
);
    reg [4:0] run_r = 5'h00;
    reg [7:0] win_r = 8'h00;
    reg [15:0] crc_r = 16'hffff;
    reg [31:0] dat_r = 32'h0;
    reg [7:0] num_r = 8'h00;
    reg [3:0] skip_r = 4'h0;
    reg lv;
    // bit clock stands high until the transmitter first comes up, then runs free
    initial
    begin
        o_clk = 1'b1;
        o_peak = 5'h00;
        #37;
        wait (i_run);
        forever
        begin
            #100 o_clk = 1'b0;
            #100 o_clk = 1'b1;
        end
    end
    // sample mid-bit, away from the falling edge
    always @(posedge o_clk)
    begin
        if (i_clr)
            o_peak = 5'h00;
        if (run_r == 5'h05 && !i_txd)
            run_r = 5'h00;
        else
        begin
            run_r = i_txd ? run_r + 5'h01 : 5'h00;
            if (run_r > o_peak)
                o_peak = run_r;
            lv = win_r[0];
            win_r = {i_txd, win_r[7:1]};
            if (skip_r != 4'h0)
                skip_r = skip_r - 4'h1;
            else
            begin
                crc_r = (crc_r >> 1) ^ ((crc_r[0] ^ lv) ? 16'h8408 : 16'h0000);
                dat_r = {lv, dat_r[31:1]};
                num_r = num_r + 8'h01;
            end
            if (win_r == 8'h7e)
            begin
                if (num_r != 8'h00)
                begin
                    o_cnt = num_r;
                    o_res = crc_r;
                    o_data = dat_r;
                end
                skip_r = 4'h8;
                num_r = 8'h00;
                crc_r = 16'hffff;
            end
        end
    end
endmodule // sft_line_model

//--- sft_frame_tx_bench.sv
`timescale 1ns/100ps
module sft_frame_tx_bench;
    logic i_sys_clk = 1'b0, i_rstn = 1'b0, i_tx_enable = 1'b0, i_send_break = 1'b0;
    logic i_rts_bit = 1'b0, i_dtr_bit = 1'b0, i_auto_enable = 1'b1, i_ext_int_enable = 1'b1;
    logic i_crc_enable = 1'b1, i_cts_n = 1'b1, i_dcd_n = 1'b1, i_buf_wr = 1'b0, clr = 1'b0;
    logic i_cmd_send_abort = 1'b0, i_cmd_reset_crc = 1'b0, i_cmd_reset_tx_int = 1'b0;
    logic i_cmd_reset_underrun = 1'b0, i_cmd_reset_ext_status = 1'b0;
    logic [2:0] i_bits_per_char = 3'h0;
    logic [7:0] i_buf_data = 8'h00;
    wire i_tx_bit_clock, o_txd, o_rts_n, o_dtr_n, o_rx_gate, o_tx_int, o_ext_status_int;
    wire o_buf_empty, o_tx_underrun_end_of_message, o_tx_dma_request;
    wire [15:0] res;
    wire [7:0] cnt;
    wire [31:0] dat;
    wire [4:0] peak;
    int num_errors = 0, checked = 0, i;
    localparam int P_WR = 0, P_ABORT = 1, P_CRC = 2, P_TXINT = 3, P_UNDERRUN = 4, P_EXT = 5;
    sft_frame_tx i_dut (.*);
    sft_line_model i_far (.i_run(i_tx_enable), .i_txd(o_txd), .i_clr(clr), .o_clk(i_tx_bit_clock),
        .o_res(res), .o_cnt(cnt), .o_data(dat), .o_peak(peak));
    initial
    begin
        forever #12.5 i_sys_clk = ~i_sys_clk;
    end
    task results;
        if (num_errors == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge i_sys_clk);
        #2;
    endtask
    task bits(input int n);
        repeat (n) @(posedge i_tx_bit_clock);
        cyc(1);
    endtask
    task pulse(input int sel);
        cyc(1);
        case (sel)
            P_WR: i_buf_wr = 1'b1;
            P_ABORT: i_cmd_send_abort = 1'b1;
            P_CRC: i_cmd_reset_crc = 1'b1;
            P_TXINT: i_cmd_reset_tx_int = 1'b1;
            P_UNDERRUN: i_cmd_reset_underrun = 1'b1;
            default: i_cmd_reset_ext_status = 1'b1;
        endcase
        cyc(1);
        {i_buf_wr, i_cmd_send_abort, i_cmd_reset_crc} = 3'h0;
        {i_cmd_reset_tx_int, i_cmd_reset_underrun, i_cmd_reset_ext_status} = 3'h0;
    endtask
    task wr(input logic [7:0] d);
        i_buf_data = d;
        pulse(P_WR);
    endtask
    task t_pins;
        chk(o_txd, 1, "txd reset");
        chk(o_tx_underrun_end_of_message, 1, "underrun reset");
        chk(o_buf_empty, 1, "empty reset");
        chk(o_rx_gate, 0, "rx gate off");
        i_rts_bit = 1'b1;
        cyc(2);
        chk({o_rts_n, o_dtr_n}, 2'b01, "modem pins");
        i_dcd_n = 1'b0;
        cyc(3);
        i_dcd_n = 1'b1;
        cyc(12);
        chk(o_ext_status_int, 0, "glitch");
        i_dcd_n = 1'b0;
        i_cts_n = 1'b0;
        cyc(16);
        chk({o_rx_gate, o_ext_status_int}, 2'b11, "dcd cts change");
        pulse(P_EXT);
        cyc(1);
        chk(o_ext_status_int, 0, "ext clear");
    endtask
    task t_break;
        i_send_break = 1'b1;
        cyc(2);
        chk(o_txd, 0, "break");
        i_send_break = 1'b0;
        cyc(2);
        chk(o_txd, 1, "unbreak");
    endtask
    task t_flags;
        i_tx_enable = 1'b1;
        clr = 1'b1;
        bits(2);
        clr = 1'b0;
        bits(24);
        chk({peak, o_tx_int, o_buf_empty}, {5'h06, 2'b01}, "idle flags");
    endtask
    task t_frame;
        pulse(P_CRC);
        wr(8'hff);
        pulse(P_UNDERRUN);
        cyc(1);
        chk({o_tx_underrun_end_of_message, o_buf_empty}, 2'b00, "frame open");
        for (i = 0; i < 800 && o_buf_empty !== 1'b1; i++) cyc(1);
        chk(o_tx_int, 1, "char taken");
        chk(o_tx_dma_request, 1, "dma request");
        wr(8'hbe);
        i_bits_per_char = 3'h7;
        cyc(1);
        chk(o_tx_int, 0, "write clears int");
        chk(o_tx_dma_request, 0, "dma request served");
        for (i = 0; i < 2000 && o_tx_underrun_end_of_message !== 1'b1; i++) cyc(1);
        chk({o_ext_status_int, o_buf_empty}, 2'b10, "crc start");
        chk(o_tx_int, 1, "last char taken");
        pulse(P_TXINT);
        cyc(1);
        chk(o_tx_int, 0, "tx int reset");
        for (i = 0; i < 4000 && cnt !== 8'd31; i++) cyc(1);
        chk(cnt, 31, "frame bits");
        chk(res, 16'hf0b8, "fcs residue");
        chk(dat[15:1], {7'h3e, 8'hff}, "frame data");
        chk({o_tx_int, o_buf_empty}, 2'b11, "flag after crc");
    endtask
    task t_abort;
        i_bits_per_char = 3'h0;
        clr = 1'b1;
        bits(1);
        clr = 1'b0;
        wr(8'h00);
        pulse(P_ABORT);
        cyc(1);
        chk(o_buf_empty, 1, "abort drops buffer");
        bits(40);
        chk(peak >= 5'd8 && peak < 5'd14, 1, "abort ones");
        clr = 1'b1;
        bits(1);
        clr = 1'b0;
        bits(24);
        chk(peak, 6, "flags after abort");
    endtask
    task t_off;
        i_tx_enable = 1'b0;
        bits(20);
        chk({o_txd, o_tx_int, o_tx_dma_request}, 3'b100, "disabled marks");
        cyc(400);
        chk(o_txd, 1, "idle mark");
    endtask
    initial
    begin
        #2000000;
        num_errors++;
        $display("[FAIL] %0t watchdog", $time);
        results;
    end
    initial
    begin
        repeat (10) @(posedge i_sys_clk);
        #2 i_rstn = 1'b1;
        cyc(2);
        t_pins;
        t_break;
        t_flags;
        t_frame;
        t_abort;
        t_off;
        results;
    end
endmodule // sft_frame_tx_bench
